// ### common/supervisor_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit Wishbone, byte addresses, one register per word
// Notes:   Times are kept in their own unit; cycles derive in the core
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

// Register byte offsets
`define SUP_ADR_MODE 6'h00
`define SUP_ADR_WD 6'h04
`define SUP_ADR_RST 6'h08
`define SUP_ADR_STAT 6'h0c

// Mode field patterns
`define SUP_MODE_NORMAL 2'h0
`define SUP_MODE_SLEEP 2'h1
`define SUP_MODE_STOP 2'h2
`define SUP_MODE_SOFTRST 2'h3

// Watchdog config register fields
`define SUP_WD_PER_LSB 0
`define SUP_WD_RSVD_BIT 3
`define SUP_WD_TYPE_BIT 4
`define SUP_WD_FS_BIT 5
`define SUP_WD_CHK_BIT 7
`define SUP_WD_RESET 8'h00

// Reset control register fields
`define SUP_RST_DELSEL_BIT 0
`define SUP_RST_SROPT_BIT 1
`define SUP_RST_CFG_LSB 2
`define SUP_RST_RESET 4'h0

// Status register fields
`define SUP_ST_FAIL_LSB 0
`define SUP_ST_SPIFAIL_BIT 2
`define SUP_ST_MODE_LSB 3
`define SUP_ST_RESET_OUT_BIT 6

// Timing, clock and oscillator tick
`define SUP_CLK_NS 5
`define SUP_TICK_NS 1000000
`define SUP_FILTER_NS 10000
`define SUP_EXT_DELAY_MS 14'd10
`define SUP_RED_DELAY_MS 14'd2
`define SUP_LONG_WIN_MS 14'd200
`define SUP_CLOSED_PCT 60
`define SUP_CS_EXEC_CYCLES 2'h3

// Watchdog periods in ms
`define SUP_WD_P0 14'd10
`define SUP_WD_P1 14'd20
`define SUP_WD_P2 14'd50
`define SUP_WD_P3 14'd100
`define SUP_WD_P4 14'd200
`define SUP_WD_P5 14'd500
`define SUP_WD_P6 14'd1000
`define SUP_WD_P7 14'd10000

`endif

// ### common/supervisor_pkg.sv
// Purpose: Types shared by the supervisor core and its bench
// Assumes: Constants live in supervisor_cfg.svh
// Notes:   Bus groups travel as packed structs
package supervisor_pkg;

  typedef enum logic [2:0] {
    M_INIT, M_NORMAL, M_SLEEP, M_STOP, M_RESTART, M_FAILSAFE
  } mode_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    mode_e mode;
    logic rst_lo;
    logic rst_n_q;
    logic rel_long;
    logic [13:0] rst_cnt;
    logic [15:0] filt_cnt;
    logic ev_f;
    logic wd_long;
    logic [13:0] wd_cnt;
    logic [7:0] wd_cfg;
    logic [3:0] rst_ctrl;
    logic [1:0] fail_cnt;
    logic spi_fail;
    logic pend;
    logic [7:0] pend_data;
    logic [1:0] exec_cnt;
    logic cs_prev;
    logic ack;
    logic [31:0] rdata;
  } sup_state_s;

endpackage

// ### core/sync2.sv
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Inputs are slow levels from outside the mclk domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // One pair of flops per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta_r[i] <= INIT[i];
          q[i] <= INIT[i];
        end else begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### core/tick_gen.sv
// Purpose: Internal oscillator tick, one pulse per millisecond
// Assumes: CYCLES is the mclk count of one tick
// Notes:   Shorten CYCLES in simulation to speed up long windows
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
  parameter int CYCLES = 200000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Tick pulse
  output logic tick
);

  logic [31:0] cnt_r;

  // Free-running divider, pulse on wrap
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r >= 32'(CYCLES - 1)) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### core/reset_and_watchdog_supervisor.sv
// Purpose: Reset output control and time-out/window watchdog
// Assumes: Registers reached over classic Wishbone, pins synchronised
// Notes:   Watchdog timing counts millisecond ticks from tick_gen
// What this block does
// - Filtered event holds reset low, plus delay
// - Extended delay default, reduced when select bit set
// - Power-up keeps reset low, releases after extended delay
// - Mode pattern 11 returns to init, defaults
// - Soft reset pulses reset unless option bit set
// - Soft reset honoured only in Normal or Stop
// - Type bit picks time-out or window watchdog
// - Watchdog config writable only in Normal mode
// - Long window after every reset release and on Normal entry from Sleep
// - Config write restarts timer with new setting
// - Trigger acts three cycles after chip select rises
// - Long open window of 200 ms accepts triggers
// - Eight periods 10 ms to 10000 ms
// - Failure resets, enters Restart or Fail-Safe, counts
// - Development mode disables watchdog resets
// - Failure counter saturates per configuration
// - Counter cleared on good trigger or while in Sleep
// - Time-out: any trigger restarts, expiry fails
// - Window: closed 60 percent, then open window
// - Window: early trigger or expiry fails
// - Bad even parity ignores write, flags failure
// - Parity includes written reserved bit 3
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_cfg.svh"
module reset_and_watchdog_supervisor #(
  parameter int TICK_CYCLES = `SUP_TICK_NS / `SUP_CLK_NS,
  parameter int FILTER_NS = `SUP_FILTER_NS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave
  input wire supervisor_pkg::wb_req_s wb_req,
  output supervisor_pkg::wb_rsp_s wb_rsp,
  // Pins from outside the clock domain
  input wire logic chip_select_n,
  input wire logic vcc1_low,
  input wire logic dev_mode,
  // Reset to the microcontroller
  output logic reset_out_n
);

  // Filter length rounded up to whole cycles, at least one
  localparam int FILT_RAW = (FILTER_NS + `SUP_CLK_NS - 1) / `SUP_CLK_NS;
  localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;

  localparam supervisor_pkg::sup_state_s RST_S = '{
    mode: supervisor_pkg::M_INIT,
    rst_lo: 1'b1,
    rel_long: 1'b1,
    wd_long: 1'b1,
    wd_cfg: `SUP_WD_RESET,
    rst_ctrl: `SUP_RST_RESET,
    cs_prev: 1'b1,
    default: '0
  };

  supervisor_pkg::sup_state_s s_r;
  supervisor_pkg::sup_state_s s_nxt;
  logic tick;
  logic [2:0] pins_s;
  logic cs_s;
  logic ev_s;
  logic dev_s;

  // Period select decode, used for limits and closed window
  function automatic logic [13:0] wd_period(input logic [2:0] c);
    case (c)
      3'h0: wd_period = `SUP_WD_P0;
      3'h1: wd_period = `SUP_WD_P1;
      3'h2: wd_period = `SUP_WD_P2;
      3'h3: wd_period = `SUP_WD_P3;
      3'h4: wd_period = `SUP_WD_P4;
      3'h5: wd_period = `SUP_WD_P5;
      3'h6: wd_period = `SUP_WD_P6;
      default: wd_period = `SUP_WD_P7;
    endcase
  endfunction

  // Closed part of a window period
  function automatic logic [13:0] wd_closed(input logic [13:0] p);
    logic [31:0] t;
    t = (32'(p) * 32'(`SUP_CLOSED_PCT)) / 32'd100;
    wd_closed = t[13:0];
  endfunction

  // Watchdog runs only in these modes, outside reset, not in dev mode
  function automatic logic wd_active(input supervisor_pkg::sup_state_s s,
                                     input logic dev);
    wd_active = !s.rst_lo && !dev &&
                (s.mode == supervisor_pkg::M_INIT ||
                 s.mode == supervisor_pkg::M_NORMAL ||
                 s.mode == supervisor_pkg::M_STOP);
  endfunction

  // Synchronised pins: chip select, reset event, development strap
  // Chip select flops reset high, its idle level: no false edge
  sync2 #(
    .W(3),
    .INIT(3'h4)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({chip_select_n, vcc1_low, dev_mode}),
    .q(pins_s)
  );

  assign cs_s = pins_s[2];
  assign ev_s = pins_s[1];
  assign dev_s = pins_s[0];

  // Millisecond oscillator tick
  tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst(rst),
    .tick(tick)
  );

  // Next-state logic for the whole block
  always_comb begin
    logic [13:0] limit;
    logic [13:0] delay;
    logic [1:0] fail_max;
    logic fail;
    logic good_trig;
    logic soft_go;
    logic soft_pulse;
    logic [7:0] wd_new;
    logic [1:0] mcmd;
    logic win_type;
    limit = 14'h0;
    delay = 14'h0;
    fail_max = 2'h0;
    fail = 1'b0;
    good_trig = 1'b0;
    soft_go = 1'b0;
    soft_pulse = 1'b0;
    wd_new = 8'h0;
    mcmd = 2'h0;
    win_type = s_r.wd_cfg[`SUP_WD_TYPE_BIT];
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.cs_prev = cs_s;

    // Reset event filter: must persist before it counts
    if (!ev_s) begin
      s_nxt.filt_cnt = 16'h0;
      s_nxt.ev_f = 1'b0;
    end else if (s_r.filt_cnt >= 16'(FILT_CYC - 1)) begin
      s_nxt.ev_f = 1'b1;
    end else begin
      s_nxt.filt_cnt = s_r.filt_cnt + 16'h1;
    end
    // A filtered event takes the reset line low at once
    if (s_r.ev_f && !s_r.rst_lo) begin
      s_nxt.rst_lo = 1'b1;
      s_nxt.rst_cnt = 14'h0;
      s_nxt.rel_long = !s_r.rst_ctrl[`SUP_RST_DELSEL_BIT];
    end

    // Reset delay runs on ticks once the event is gone
    delay = s_r.rel_long ? `SUP_EXT_DELAY_MS : `SUP_RED_DELAY_MS;
    if (s_r.rst_lo) begin
      if (s_r.ev_f) begin
        s_nxt.rst_cnt = 14'h0;
      end else if (tick) begin
        if (s_r.rst_cnt + 14'h1 >= delay) begin
          s_nxt.rst_lo = 1'b0;
          s_nxt.wd_long = 1'b1;
          s_nxt.wd_cnt = 14'h0;
          if (s_r.mode == supervisor_pkg::M_RESTART) begin
            s_nxt.mode = supervisor_pkg::M_NORMAL;
          end
        end else begin
          s_nxt.rst_cnt = s_r.rst_cnt + 14'h1;
        end
      end
    end

    // Watchdog timer: long window or selected period
    limit = s_r.wd_long ? `SUP_LONG_WIN_MS
          : wd_period(s_r.wd_cfg[`SUP_WD_PER_LSB +: 3]);
    if (wd_active(s_r, dev_s) && tick) begin
      if (s_r.wd_cnt + 14'h1 >= limit) begin
        fail = 1'b1;
      end else begin
        s_nxt.wd_cnt = s_r.wd_cnt + 14'h1;
      end
    end

    // Pending watchdog write waits for chip select to rise
    if (s_r.pend && cs_s && !s_r.cs_prev) begin
      s_nxt.exec_cnt = `SUP_CS_EXEC_CYCLES;
    end else if (s_r.exec_cnt != 2'h0) begin
      s_nxt.exec_cnt = s_r.exec_cnt - 2'h1;
    end
    // Parity covers all eight written bits, reserved bit too
    if (s_r.exec_cnt == 2'h1 && s_r.pend) begin
      s_nxt.pend = 1'b0;
      if (^s_r.pend_data) begin
        s_nxt.spi_fail = 1'b1;
      end else if (wd_active(s_r, dev_s)) begin
        if (!s_r.wd_long && win_type &&
            s_r.wd_cnt < wd_closed(limit)) begin
          fail = 1'b1;
        end else begin
          good_trig = 1'b1;
        end
      end
    end
    // A good trigger opens a fresh period from zero
    if (good_trig) begin
      s_nxt.wd_long = 1'b0;
      s_nxt.wd_cnt = 14'h0;
      s_nxt.fail_cnt = 2'h0;
      if (s_r.mode == supervisor_pkg::M_NORMAL) begin
        wd_new = s_r.pend_data;
        wd_new[`SUP_WD_RSVD_BIT] = 1'b0;
        s_nxt.wd_cfg = wd_new;
      end
    end

    // Watchdog failure: count, reset, enter Restart or Fail-Safe
    fail_max = (s_r.rst_ctrl[`SUP_RST_CFG_LSB +: 2] == 2'h1) ? 2'h1 : 2'h2;
    // Expiry beats a trigger landing in the same cycle
    if (fail) begin
      if (s_r.fail_cnt < fail_max) begin
        s_nxt.fail_cnt = s_r.fail_cnt + 2'h1;
      end
      s_nxt.rst_lo = 1'b1;
      s_nxt.rst_cnt = 14'h0;
      s_nxt.rel_long = !s_r.rst_ctrl[`SUP_RST_DELSEL_BIT];
      s_nxt.mode = s_r.wd_cfg[`SUP_WD_FS_BIT] ?
                   supervisor_pkg::M_FAILSAFE :
                   supervisor_pkg::M_RESTART;
    end

    // Wishbone slave: one wait cycle, unmapped reads give zero
    if (wb_req.cyc && wb_req.stb && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      case (wb_req.adr)
        `SUP_ADR_MODE: s_nxt.rdata = {29'h0, 3'(s_r.mode)};
        `SUP_ADR_WD: s_nxt.rdata = {24'h0, s_r.wd_cfg};
        `SUP_ADR_RST: s_nxt.rdata = {28'h0, s_r.rst_ctrl};
        `SUP_ADR_STAT: s_nxt.rdata = {25'h0, s_r.rst_n_q,
                                      3'(s_r.mode), s_r.spi_fail,
                                      s_r.fail_cnt};
        default: s_nxt.rdata = 32'h0;
      endcase
      if (wb_req.we && wb_req.sel[0]) begin
        mcmd = wb_req.dat[1:0];
        case (wb_req.adr)
          `SUP_ADR_MODE: begin
            if (mcmd == `SUP_MODE_SOFTRST) begin
              soft_go = (s_r.mode == supervisor_pkg::M_NORMAL ||
                         s_r.mode == supervisor_pkg::M_STOP);
            end else if (mcmd == `SUP_MODE_NORMAL &&
                         (s_r.mode == supervisor_pkg::M_INIT ||
                          s_r.mode == supervisor_pkg::M_SLEEP ||
                          s_r.mode == supervisor_pkg::M_STOP)) begin
              s_nxt.mode = supervisor_pkg::M_NORMAL;
              if (s_r.mode == supervisor_pkg::M_SLEEP) begin
                s_nxt.wd_long = 1'b1;
                s_nxt.wd_cnt = 14'h0;
              end
            end else if (mcmd == `SUP_MODE_SLEEP &&
                         s_r.mode == supervisor_pkg::M_NORMAL) begin
              s_nxt.mode = supervisor_pkg::M_SLEEP;
              s_nxt.fail_cnt = 2'h0;
            end else if (mcmd == `SUP_MODE_STOP &&
                         s_r.mode == supervisor_pkg::M_NORMAL) begin
              s_nxt.mode = supervisor_pkg::M_STOP;
            end
          end
          `SUP_ADR_WD: begin
            s_nxt.pend = 1'b1;
            s_nxt.pend_data = wb_req.dat[7:0];
            s_nxt.exec_cnt = 2'h0;
          end
          `SUP_ADR_RST: s_nxt.rst_ctrl = wb_req.dat[3:0];
          `SUP_ADR_STAT: begin
            if (wb_req.dat[`SUP_ST_SPIFAIL_BIT] && s_nxt.spi_fail &&
                !(s_r.exec_cnt == 2'h1 && s_r.pend && ^s_r.pend_data)) begin
              s_nxt.spi_fail = 1'b0; // Set wins over clear
            end
          end
          default: ;
        endcase
      end
    end

    // Sleep has the watchdog off, so its counter stays clear
    if (s_nxt.mode == supervisor_pkg::M_SLEEP) begin
      s_nxt.fail_cnt = 2'h0;
    end

    // Soft reset: back to init, registers to defaults except the serial failure flag
    if (soft_go) begin
      soft_pulse = !s_r.rst_ctrl[`SUP_RST_SROPT_BIT];
      s_nxt = RST_S;
      s_nxt.cs_prev = cs_s;
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 32'h0;
      // Filter and serial failure flag survive a soft reset
      s_nxt.filt_cnt = s_r.filt_cnt;
      s_nxt.ev_f = s_r.ev_f;
      s_nxt.spi_fail = s_r.spi_fail;
      if (!soft_pulse && !s_r.rst_lo) begin
        s_nxt.rst_lo = 1'b0;
      end else begin
        s_nxt.rst_lo = 1'b1;
        s_nxt.rel_long = 1'b1;
      end
    end

    // Registered copy keeps the reset pin free of glitches
    s_nxt.rst_n_q = !s_nxt.rst_lo;
  end

  // State register, starts in init with reset held low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= RST_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign reset_out_n = s_r.rst_n_q;
  assign wb_rsp.ack = s_r.ack;
  assign wb_rsp.dat = s_r.rdata;

endmodule
`default_nettype wire

// ### bench/supervisor_props.sv
// Purpose: Port-level checks of the reset and watchdog supervisor
// Assumes: Bound to the top module; one clock domain
// Notes:   Delay bounds allow one tick of phase slack
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_cfg.svh"
module supervisor_props #(
  parameter int TICK_CYCLES = 200000,
  parameter int FILTER_NS = 10000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register bus
  input wire supervisor_pkg::wb_req_s wb_req,
  input wire supervisor_pkg::wb_rsp_s wb_rsp,
  // Pins
  input wire logic chip_select_n,
  input wire logic vcc1_low,
  input wire logic dev_mode,
  input wire logic reset_out_n
);
  logic [15:0] lo_run_r;
  logic [15:0] gone_r;
  logic rd_st;
  logic rd_wd;

  // Saturating run lengths of reset low and of event absence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lo_run_r <= 16'h0;
      gone_r <= 16'h0;
    end else begin
      lo_run_r <= reset_out_n ? 16'h0 : lo_run_r + {15'h0, ~&lo_run_r};
      gone_r <= vcc1_low ? 16'h0 : gone_r + {15'h0, ~&gone_r};
    end
  end

  // Read answers; the master holds the address through ack
  assign rd_st = wb_rsp.ack && !wb_req.we && wb_req.adr == `SUP_ADR_STAT;
  assign rd_wd = wb_rsp.ack && !wb_req.we && wb_req.adr == `SUP_ADR_WD;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Event seen long enough to pass sync and filter
  sequence ev_held;
    vcc1_low [*8];
  endsequence

  ack_one_cycle_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack stood longer than one cycle");
  ack_has_req_a: assert property ($rose(wb_rsp.ack) |->
    $past(wb_req.cyc && wb_req.stb)) else $error("ack without request");
  event_pulls_a: assert property (ev_held |-> ##[0:8] !reset_out_n)
    else $error("reset not pulled low by held event");
  event_holds_a: assert property (ev_held ##0 !reset_out_n |=>
    !reset_out_n) else $error("reset released during event");
  release_gap_a: assert property ($rose(reset_out_n) |->
    int'(gone_r) >= TICK_CYCLES) else $error("release too soon after event");
  low_length_a: assert property ($rose(reset_out_n) |->
    int'(lo_run_r) >= TICK_CYCLES) else $error("reset pulse too short");
  rsvd_reads_a: assert property (rd_wd |->
    !wb_rsp.dat[`SUP_WD_RSVD_BIT]) else $error("reserved bit read as one");
  fail_sat_a: assert property (rd_st |->
    wb_rsp.dat[1:0] != 2'h3) else $error("failure count beyond maximum");
  mode_code_a: assert property (rd_st |-> wb_rsp.dat[5:3] <= 3'h5)
    else $error("mode code out of range");
endmodule
`default_nettype wire

// ### bench/host_spi.sv
// Purpose: Host side of the watchdog link, one chip select frame
// Assumes: A request is go held high until done is seen
// Notes:   Link clock runs only inside a frame
`timescale 1ns/1ps
`default_nettype none
module host_spi (
  // Request
  input wire logic go,
  output logic done,
  // Link pin
  output logic chip_select_n
);
  logic sck;

  // Frame of four link clocks, then deselect to trigger
  always begin
    chip_select_n = 1'b1;
    done = 1'b0;
    sck = 1'b0;
    wait (go === 1'b1);
    chip_select_n = 1'b0;
    repeat (8) #32 sck = ~sck;
    #32 chip_select_n = 1'b1;
    done = 1'b1;
    wait (go === 1'b0);
  end
endmodule
`default_nettype wire

// ### bench/reset_and_watchdog_supervisor_bench.sv
// Purpose: Self-checking bench of the reset and watchdog supervisor
// Assumes: One ms tick is TK clocks; frames come from host_spi
// Notes:   Trigger spacing includes about 72 cycles of frame overhead
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_cfg.svh"
module reset_and_watchdog_supervisor_bench;
  localparam int TK = 20;
  localparam int EXT = 10 * TK;
  localparam int RED = 2 * TK;
  localparam int P0 = 10 * TK;
  localparam logic [5:0] MD = `SUP_ADR_MODE;
  localparam logic [5:0] WA = `SUP_ADR_WD;
  localparam logic [5:0] RC = `SUP_ADR_RST;
  localparam logic [5:0] ST = `SUP_ADR_STAT;
  logic mclk;
  logic rst;
  supervisor_pkg::wb_req_s req;
  supervisor_pkg::wb_rsp_s rsp;
  logic chip_select_n;
  logic vcc1_low;
  logic dev_mode;
  logic reset_out_n;
  logic go;
  logic done;
  logic [31:0] r;
  int n_errors;
  int samples_checked;
  int tcount;

  reset_and_watchdog_supervisor #(.TICK_CYCLES(TK), .FILTER_NS(20))
      reset_and_watchdog_supervisor_inst (
    .mclk(mclk), .rst(rst), .wb_req(req), .wb_rsp(rsp),
    .chip_select_n(chip_select_n), .vcc1_low(vcc1_low),
    .dev_mode(dev_mode), .reset_out_n(reset_out_n));
  host_spi host_spi_inst (.go(go), .done(done),
    .chip_select_n(chip_select_n));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task end_sim();
    $display("Checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, far above the planned run length
  always @(posedge mclk) begin
    tcount <= tcount + 1;
    if (tcount == 40000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle; everything held until ack is sampled
  task bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do @(posedge mclk); while (rsp.ack !== 1'b1);
    r = rsp.dat;
    req <= '0;
  endtask

  // A write only counts once the frame deselects
  task wd(input logic [7:0] d);
    bus(1'b1, WA, {24'h0, d});
    go <= 1'b1;
    do @(posedge mclk); while (done !== 1'b1);
    go <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask

  task edge_in(input string nm, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (reset_out_n !== lvl && n <= hi) begin
      @(posedge mclk);
      n++;
    end
    samples_checked++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("[FAIL] %s expected %0d to %0d seen %0d", nm, lo, hi, n);
    end
  endtask

  task t_init();
    edge_in("power-up", 1'b1, EXT - TK, EXT + 2 * TK);
    bus(1'b0, ST, 32'h0);
    chk("init mode", 32'h0, {29'h0, r[5:3]});
    bus(1'b0, RC, 32'h0);
    chk("reset ctrl", 32'h0, r);
    bus(1'b0, 6'h10, 32'h0);
    chk("unmapped", 32'h0, r);
    bus(1'b1, MD, 32'h0);
  endtask

  task t_parity();
    logic [2:0] c;
    wd(8'h01);
    bus(1'b0, ST, 32'h0);
    chk("spi fail", 32'h1, {31'h0, r[2]});
    bus(1'b1, ST, 32'h4);
    bus(1'b0, ST, 32'h0);
    chk("fail clear", 32'h0, {31'h0, r[2]});
    bus(1'b0, WA, 32'h0);
    chk("bad parity cfg", 32'h0, {29'h0, r[2:0]});
    wd(8'h09);
    bus(1'b0, WA, 32'h0);
    chk("rsvd parity", 32'h1, {28'h0, r[3:0]});
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wd({^c, 4'h0, c});
      bus(1'b0, WA, 32'h0);
      chk("period", {29'h0, c}, {29'h0, r[2:0]});
    end
  endtask

  task t_timeout();
    wd(8'h00);
    repeat (3) begin
      repeat (80) @(posedge mclk);
      wd(8'h00);
      chk("served", 32'h1, {31'h0, reset_out_n});
    end
    edge_in("expiry", 1'b0, P0 - TK - 10, P0 + TK + 20);
    bus(1'b0, ST, 32'h0);
    chk("fail count", 32'h1, {30'h0, r[1:0]});
    chk("restart", 32'h4, {29'h0, r[5:3]});
    edge_in("wd delay", 1'b1, EXT - TK, EXT + 2 * TK);
    repeat (3 * P0) @(posedge mclk);
    chk("long window", 32'h1, {31'h0, reset_out_n});
    bus(1'b0, ST, 32'h0);
    chk("normal again", 32'h1, {29'h0, r[5:3]});
    wd(8'h00);
    bus(1'b0, ST, 32'h0);
    chk("count cleared", 32'h0, {30'h0, r[1:0]});
  endtask

  task t_window();
    wd(8'h90);
    repeat (85) @(posedge mclk);
    wd(8'h90);
    chk("open trigger", 32'h1, {31'h0, reset_out_n});
    wd(8'h90);
    edge_in("closed trigger", 1'b0, 0, 30);
    edge_in("wd delay 2", 1'b1, EXT - TK, EXT + 2 * TK);
    bus(1'b0, WA, 32'h0);
    chk("window type", 32'h1, {31'h0, r[4]});
  endtask

  task t_stop_soft();
    bus(1'b1, MD, 32'h1);
    bus(1'b0, ST, 32'h0);
    chk("sleep clears", 32'h10, {26'h0, r[5:0]});
    bus(1'b1, MD, 32'h0);
    bus(1'b1, MD, 32'h2);
    wd(8'h81);
    bus(1'b0, WA, 32'h0);
    chk("stop keeps cfg", 32'h10, {27'h0, r[4:0]});
    bus(1'b1, MD, 32'h3);
    edge_in("soft pulse", 1'b0, 0, 30);
    edge_in("soft delay", 1'b1, EXT - TK, EXT + 2 * TK);
    bus(1'b0, WA, 32'h0);
    chk("cfg default", 32'h0, {27'h0, r[4:0]});
    bus(1'b1, MD, 32'h3);
    repeat (30) @(posedge mclk);
    chk("init ignores", 32'h1, {31'h0, reset_out_n});
    bus(1'b1, MD, 32'h0);
    bus(1'b1, RC, 32'h2);
    bus(1'b1, MD, 32'h3);
    repeat (30) @(posedge mclk);
    chk("no pulse", 32'h1, {31'h0, reset_out_n});
    bus(1'b0, ST, 32'h0);
    chk("soft init", 32'h0, {29'h0, r[5:3]});
    bus(1'b0, RC, 32'h0);
    chk("ctrl default", 32'h0, r);
  endtask

  task t_event_dev();
    bus(1'b1, MD, 32'h0);
    bus(1'b1, RC, 32'h1);
    vcc1_low <= 1'b1;
    edge_in("filter", 1'b0, 4, 12);
    repeat (50) @(posedge mclk);
    chk("event low", 32'h0, {31'h0, reset_out_n});
    vcc1_low <= 1'b0;
    edge_in("reduced", 1'b1, RED - TK, RED + 2 * TK);
    dev_mode <= 1'b1;
    bus(1'b1, MD, 32'h0);
    wd(8'h00);
    repeat (3 * P0) @(posedge mclk);
    chk("dev no reset", 32'h1, {31'h0, reset_out_n});
  endtask

  initial begin
    n_errors = 0;
    samples_checked = 0;
    tcount = 0;
    rst = 1'b1;
    req = '0;
    vcc1_low = 1'b0;
    dev_mode = 1'b0;
    go = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_init();
    t_parity();
    t_timeout();
    t_window();
    t_stop_soft();
    t_event_dev();
    end_sim();
  end
endmodule

bind reset_and_watchdog_supervisor supervisor_props #(
  .TICK_CYCLES(TICK_CYCLES), .FILTER_NS(FILTER_NS)) supervisor_props_inst (
  .mclk(mclk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .chip_select_n(chip_select_n), .vcc1_low(vcc1_low),
  .dev_mode(dev_mode), .reset_out_n(reset_out_n));
`default_nettype wire
